// [src/pie_consts.svh]
// Purpose: Offsets, field positions, reset values and counts for the PHY irq/control bank
// Assumes: 32-bit AXI4-Lite data, one aligned word per register
// Notes: Status register offset is a local choice
`ifndef PIE_CONSTS_SVH
`define PIE_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PIE_OFF_EVT_STATUS 8'hD4
`define PIE_OFF_IRQ_EN 8'hD8
`define PIE_OFF_FTX_CTL 8'hDC

// ----------------------------------------------------------------
// Event status / enable bit positions
// ----------------------------------------------------------------
`define PIE_EVT_NEG_DONE 6
`define PIE_EVT_REMOTE_FAULT 5
`define PIE_EVT_LINK_DOWN 4
`define PIE_EVT_ACK_RX 3
`define PIE_EVT_DETECT_FAULT 2
`define PIE_EVT_PAGE_RX 1
`define PIE_EVT_ERR_FULL 0
`define PIE_EVT_W 7

// ----------------------------------------------------------------
// Fast transmit control bit positions
// ----------------------------------------------------------------
`define PIE_FTX_ERR_CNT_OFF 13
`define PIE_FTX_NEG_DONE 12
`define PIE_FTX_FAR_LOOP 9
`define PIE_FTX_BASELINE 8
`define PIE_FTX_LINE_CODE 7
`define PIE_FTX_TX_ISO 5
`define PIE_FTX_OPSTATE_HI 4
`define PIE_FTX_OPSTATE_LO 2
`define PIE_FTX_TERNARY 1
`define PIE_FTX_SCRAMBLER 0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define PIE_RST_IRQ_EN 7'h00
`define PIE_RST_BASELINE 1'h1
`define PIE_RST_LINE_CODE 1'h1
`define PIE_ERR_FULL_COUNT 7'h40
`define PIE_MAC_LOOP_NONE 2'h0
`define PIE_RESP_OKAY 2'h0
`define PIE_RESP_SLVERR 2'h2

`endif

// [src/pie_pkg.sv]
// Purpose: Types for the PHY irq/control bank
// Assumes: Constants come from pie_consts.svh
// Notes: All module state is one packed struct
`include "pie_consts.svh"

package pie_pkg;

  // ----------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PIE_SEL_NONE = 2'b00,
    PIE_SEL_STATUS = 2'b01,
    PIE_SEL_IRQ_EN = 2'b10,
    PIE_SEL_FTX = 2'b11
  } pie_sel_type;

  // ----------------------------------------------------------------
  // Transceiver event inputs, one-cycle pulses
  // ----------------------------------------------------------------
  typedef struct packed {
    logic remote_fault;
    logic link_down;
    logic ack_rx;
    logic detect_fault;
    logic page_rx;
    logic rx_err;
  } pie_evt_type;

  // ----------------------------------------------------------------
  // Fast transmit control outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic err_counter_off;
    logic far_loopback_en;
    logic baseline_restore_en;
    logic line_inversion_code_en;
    logic transmit_isolate;
    logic ternary_code_bypass;
    logic scrambler_bypass;
  } pie_ftx_type;

  // ----------------------------------------------------------------
  // Whole module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic aw_hit;
    logic w_held;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [6:0] irq_en;
    logic far_loop_req;
    pie_ftx_type ftx;
    logic [6:0] status;
    logic [6:0] err_cnt;
    logic neg_prev;
    logic irq;
  } pie_state_type;

endpackage : pie_pkg

// [src/pie_regs.sv]
// Purpose: PHY event status, interrupt enable and fast transmit control registers
// Assumes: Event, mode and status inputs come from logic on ref_clk
// Notes: AXI4-Lite slave, one write and one read outstanding at most
//
// How it works
// R1: Error-full flag sets at 64 errored packets
// R2: Latched flags hold until read, read clears
// R3: Enable bit 6 gates negotiation-done interrupt
// R4: Enable bit 5 gates remote-fault interrupt
// R5: Enable bit 4 gates link-down interrupt
// R6: Enable bit 3 gates acknowledge-received interrupt
// R7: Enable bit 2 gates detection-fault interrupt
// R8: Enable bit 1 gates page-received interrupt
// R9: Enable bit 0 gates error-full interrupt
// R10: Interrupt high while any enabled flag set
// R11: Counter-off bit stops receive error counting
// R12: Bit 12 mirrors negotiation-done status
// R13: Bit 9 far loopback, only with MAC loop 00
// R14: Bit 8 baseline restore, resets to one
// R15: Bit 7 line code conversion, resets one
// R16: Bit 5 isolates transmitter, resets zero
// R17: Bits 4..2 report current operating state
// R18: Bit 1 bypasses ternary encoder and decoder
// R19: Bit 0 bypasses scrambler and descrambler
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pie_consts.svh"

module pie_regs
  import pie_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transceiver side
  input wire pie_evt_type evt,
  input wire logic negotiation_done,
  input wire logic [2:0] operating_state,
  input wire logic [1:0] mac_loop_mode,
  output pie_ftx_type ftx,
  output logic phy_irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W must be at least 8");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic pie_sel_type decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = {addr[ADDR_W-1:2], 2'h0};
    if (word == ADDR_W'(`PIE_OFF_EVT_STATUS)) begin
      decode = PIE_SEL_STATUS;
    end else if (word == ADDR_W'(`PIE_OFF_IRQ_EN)) begin
      decode = PIE_SEL_IRQ_EN;
    end else if (word == ADDR_W'(`PIE_OFF_FTX_CTL)) begin
      decode = PIE_SEL_FTX;
    end else begin
      decode = PIE_SEL_NONE;
    end
  endfunction : decode

  function automatic logic [15:0] ftx_word(input pie_state_type s,
                                           input logic neg_done,
                                           input logic [2:0] opstate);
    logic [15:0] v;
    v = 16'h0000;
    v[`PIE_FTX_ERR_CNT_OFF] = s.ftx.err_counter_off;
    v[`PIE_FTX_NEG_DONE] = neg_done; // R12
    v[`PIE_FTX_FAR_LOOP] = s.far_loop_req;
    v[`PIE_FTX_BASELINE] = s.ftx.baseline_restore_en;
    v[`PIE_FTX_LINE_CODE] = s.ftx.line_inversion_code_en;
    v[`PIE_FTX_TX_ISO] = s.ftx.transmit_isolate;
    v[`PIE_FTX_OPSTATE_HI:`PIE_FTX_OPSTATE_LO] = opstate; // R17
    v[`PIE_FTX_TERNARY] = s.ftx.ternary_code_bypass;
    v[`PIE_FTX_SCRAMBLER] = s.ftx.scrambler_bypass;
    ftx_word = v;
  endfunction : ftx_word

  pie_state_type st_q;
  pie_state_type st_d;
  pie_sel_type rd_sel;
  pie_sel_type wr_sel;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_go;
  logic status_rd;
  logic [6:0] events;
  logic [6:0] rd_clear;

  always_comb begin
    rd_sel = decode(s_axi_araddr);
    wr_sel = decode(ADDR_W'(st_q.aw_addr));
    aw_take = s_axi_awvalid && st_q.awready;
    w_take = s_axi_wvalid && st_q.wready;
    ar_take = s_axi_arvalid && st_q.arready;
    wr_go = st_q.aw_held && st_q.w_held && !st_q.bvalid;
    status_rd = ar_take && (rd_sel == PIE_SEL_STATUS);
    events = 7'h00;
    rd_clear = 7'h00;
    st_d = st_q;

    // ----------------------------------------------------------------
    // Write channel capture, either order
    // ----------------------------------------------------------------
    if (aw_take) begin
      st_d.aw_held = 1'h1;
      st_d.aw_addr = s_axi_awaddr[7:0];
      st_d.aw_hit = (decode(s_axi_awaddr) != PIE_SEL_NONE);
    end
    if (w_take) begin
      st_d.w_held = 1'h1;
      st_d.w_data = s_axi_wdata[15:0];
      st_d.w_strb = s_axi_wstrb[1:0];
    end
    st_d.awready = !st_d.aw_held && !st_q.bvalid;
    st_d.wready = !st_d.w_held && !st_q.bvalid;

    // ----------------------------------------------------------------
    // Register write and response
    // ----------------------------------------------------------------
    if (wr_go) begin
      st_d.aw_held = 1'h0;
      st_d.w_held = 1'h0;
      st_d.bvalid = 1'h1;
      st_d.bresp = st_q.aw_hit ? `PIE_RESP_OKAY : `PIE_RESP_SLVERR;
      if (st_q.aw_hit && wr_sel == PIE_SEL_IRQ_EN && st_q.w_strb[0]) begin
        st_d.irq_en = st_q.w_data[6:0]; // R3 R4 R5 R6 R7 R8 R9
      end
      if (st_q.aw_hit && wr_sel == PIE_SEL_FTX) begin
        if (st_q.w_strb[1]) begin
          st_d.ftx.err_counter_off = st_q.w_data[`PIE_FTX_ERR_CNT_OFF];
          st_d.far_loop_req = st_q.w_data[`PIE_FTX_FAR_LOOP];
          st_d.ftx.baseline_restore_en = st_q.w_data[`PIE_FTX_BASELINE]; // R14
        end
        if (st_q.w_strb[0]) begin
          st_d.ftx.line_inversion_code_en = st_q.w_data[`PIE_FTX_LINE_CODE]; // R15
          st_d.ftx.transmit_isolate = st_q.w_data[`PIE_FTX_TX_ISO]; // R16
          st_d.ftx.ternary_code_bypass = st_q.w_data[`PIE_FTX_TERNARY]; // R18
          st_d.ftx.scrambler_bypass = st_q.w_data[`PIE_FTX_SCRAMBLER]; // R19
        end
      end
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'h0;
      st_d.awready = !st_d.aw_held;
      st_d.wready = !st_d.w_held;
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    if (ar_take) begin
      st_d.arready = 1'h0;
      st_d.rvalid = 1'h1;
      st_d.rresp = `PIE_RESP_OKAY;
      case (rd_sel)
        PIE_SEL_STATUS: begin
          st_d.rdata = {25'h0000000, st_q.status}; // R2
          rd_clear = st_q.status;
        end
        PIE_SEL_IRQ_EN: begin
          st_d.rdata = {25'h0000000, st_q.irq_en};
        end
        PIE_SEL_FTX: begin
          st_d.rdata = {16'h0000, ftx_word(st_q, st_q.neg_prev, operating_state)};
        end
        default: begin
          st_d.rdata = 32'h00000000;
          st_d.rresp = `PIE_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'h0;
      st_d.arready = 1'h1;
    end

    // ----------------------------------------------------------------
    // Receive error counter
    // ----------------------------------------------------------------
    if (status_rd && st_q.status[`PIE_EVT_ERR_FULL]) begin
      st_d.err_cnt = 7'h00;
    end
    if (evt.rx_err && !st_q.ftx.err_counter_off // R11
        && st_d.err_cnt != `PIE_ERR_FULL_COUNT) begin
      st_d.err_cnt = st_d.err_cnt + 7'h01;
    end
    // R1
    events[`PIE_EVT_ERR_FULL] = (st_d.err_cnt == `PIE_ERR_FULL_COUNT)
                                && (st_q.err_cnt != `PIE_ERR_FULL_COUNT);

    // ----------------------------------------------------------------
    // Latched event flags, set wins over read clear
    // ----------------------------------------------------------------
    st_d.neg_prev = negotiation_done;
    events[`PIE_EVT_NEG_DONE] = negotiation_done && !st_q.neg_prev;
    events[`PIE_EVT_REMOTE_FAULT] = evt.remote_fault;
    events[`PIE_EVT_LINK_DOWN] = evt.link_down;
    events[`PIE_EVT_ACK_RX] = evt.ack_rx;
    events[`PIE_EVT_DETECT_FAULT] = evt.detect_fault;
    events[`PIE_EVT_PAGE_RX] = evt.page_rx;
    st_d.status = (st_q.status & ~rd_clear) | events; // R2

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    st_d.irq = |(st_d.status & st_d.irq_en); // R10
    st_d.ftx.far_loopback_en = st_d.far_loop_req
                               && (mac_loop_mode == `PIE_MAC_LOOP_NONE); // R13
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.awready <= 1'h1;
      st_q.wready <= 1'h1;
      st_q.arready <= 1'h1;
      st_q.irq_en <= `PIE_RST_IRQ_EN;
      st_q.ftx.baseline_restore_en <= `PIE_RST_BASELINE; // R14
      st_q.ftx.line_inversion_code_en <= `PIE_RST_LINE_CODE; // R15
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign ftx = st_q.ftx;
  assign phy_irq = st_q.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_err_full_at_count;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(st_q.status[`PIE_EVT_ERR_FULL]) |-> st_q.err_cnt == 7'h40;
  endproperty
  a_err_full_at_count: assert property (p_err_full_at_count) // R1
    else $error("error-full flag set away from count 64");

  property p_err_below_count;
    @(posedge ref_clk) disable iff (sys_rst)
    (st_q.err_cnt < 7'h40) && !st_q.status[`PIE_EVT_ERR_FULL]
      && !(evt.rx_err && !st_q.ftx.err_counter_off) |=> !st_q.status[`PIE_EVT_ERR_FULL];
  endproperty
  a_err_below_count: assert property (p_err_below_count) // R1
    else $error("error-full flag set below count 64");

  property p_read_clears;
    @(posedge ref_clk) disable iff (sys_rst)
    (status_rd && st_q.status[`PIE_EVT_LINK_DOWN] && !evt.link_down)
      |=> s_axi_rvalid && s_axi_rdata[`PIE_EVT_LINK_DOWN] && !st_q.status[`PIE_EVT_LINK_DOWN];
  endproperty
  a_read_clears: assert property (p_read_clears) // R2
    else $error("latched flag not returned then cleared by read");

  property p_flag_holds;
    @(posedge ref_clk) disable iff (sys_rst)
    st_q.status[`PIE_EVT_PAGE_RX] && !status_rd |=> st_q.status[`PIE_EVT_PAGE_RX];
  endproperty
  a_flag_holds: assert property (p_flag_holds) // R2
    else $error("latched flag dropped without a read");

  property p_irq_gate;
    @(posedge ref_clk) disable iff (sys_rst)
    ##1 phy_irq == |($past(st_d.status) & $past(st_d.irq_en));
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R3 R4 R5 R6 R7 R8 R9 R10
    else $error("interrupt does not match enabled flags");

  property p_masked_quiet;
    @(posedge ref_clk) disable iff (sys_rst)
    st_q.irq_en == 7'h00 && !wr_go |=> !phy_irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) // R10
    else $error("interrupt raised with all enables clear");

  property p_counter_off;
    @(posedge ref_clk) disable iff (sys_rst)
    st_q.ftx.err_counter_off && !status_rd |=> $stable(st_q.err_cnt);
  endproperty
  a_counter_off: assert property (p_counter_off) // R11
    else $error("error counter moved while disabled");

  property p_ftx_read;
    @(posedge ref_clk) disable iff (sys_rst)
    ar_take && rd_sel == PIE_SEL_FTX |=> s_axi_rvalid
      && s_axi_rdata[`PIE_FTX_NEG_DONE] == $past(st_q.neg_prev)
      && s_axi_rdata[4:2] == $past(operating_state);
  endproperty
  a_ftx_read: assert property (p_ftx_read) // R12 R17
    else $error("control read lost mirror or operating state");

  property p_far_loop;
    @(posedge ref_clk) disable iff (sys_rst)
    ##1 ftx.far_loopback_en |-> $past(mac_loop_mode) == 2'h0 && st_q.far_loop_req;
  endproperty
  a_far_loop: assert property (p_far_loop) // R13
    else $error("far loopback on with MAC loop mode set");

  property p_reset_values;
    @(posedge ref_clk)
    $fell(sys_rst) |-> ftx.baseline_restore_en && ftx.line_inversion_code_en
      && !ftx.transmit_isolate && !ftx.ternary_code_bypass && !ftx.scrambler_bypass;
  endproperty
  a_reset_values: assert property (p_reset_values) // R14 R15 R16 R18 R19
    else $error("control outputs wrong after reset");

  property p_ctl_write;
    @(posedge ref_clk) disable iff (sys_rst)
    wr_go && st_q.aw_hit && wr_sel == PIE_SEL_FTX && st_q.w_strb[0]
      |=> ftx.scrambler_bypass == $past(st_q.w_data[0])
      && ftx.ternary_code_bypass == $past(st_q.w_data[1])
      && ftx.transmit_isolate == $past(st_q.w_data[5]);
  endproperty
  a_ctl_write: assert property (p_ctl_write) // R16 R18 R19
    else $error("control write not applied");

  property p_irq_en_write;
    @(posedge ref_clk) disable iff (sys_rst)
    wr_go && st_q.aw_hit && wr_sel == PIE_SEL_IRQ_EN && st_q.w_strb[0]
      |=> st_q.irq_en == $past(st_q.w_data[6:0]);
  endproperty
  a_irq_en_write: assert property (p_irq_en_write) // R3 R4 R5 R6 R7 R8 R9
    else $error("enable write not applied");

  property p_set_wins;
    @(posedge ref_clk) disable iff (sys_rst)
    status_rd && evt.link_down |=> st_q.status[`PIE_EVT_LINK_DOWN];
  endproperty
  a_set_wins: assert property (p_set_wins) // R2
    else $error("read clear beat a new event");

  property p_neg_event;
    @(posedge ref_clk) disable iff (sys_rst)
    negotiation_done && !st_q.neg_prev |=> st_q.status[`PIE_EVT_NEG_DONE];
  endproperty
  a_neg_event: assert property (p_neg_event) // R2
    else $error("negotiation-done edge not latched");

  property p_err_restart;
    @(posedge ref_clk) disable iff (sys_rst)
    status_rd && st_q.status[`PIE_EVT_ERR_FULL] && !evt.rx_err |=> st_q.err_cnt == 7'h00;
  endproperty
  a_err_restart: assert property (p_err_restart) // R1
    else $error("error counter not restarted by clearing read");

endmodule : pie_regs

// [testbench/phy_irq_enable_and_fast_tx_control_tb.sv]
// Purpose: Self-checking bench for the PHY irq and control register bank
// Assumes: AXI4-Lite master driven on ref_clk rising edges, registered slave outputs
// Notes: Table rows cover register access; hand tests cover events, counter and reset
`timescale 1ns/1ps
`include "pie_consts.svh"

module phy_irq_enable_and_fast_tx_control_tb import pie_pkg::*;;
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] d;
    logic [3:0] s;
    logic [15:0] e;
    logic [1:0] r;
  } pie_row_type;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  pie_evt_type evt = '0;
  logic negotiation_done = 1'b0;
  logic [2:0] operating_state = 3'h5;
  logic [1:0] mac_loop_mode = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, phy_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  pie_ftx_type ftx;
  int mismatches = 0;
  int n_compared = 0;
  logic [1:0] r;
  logic [31:0] d;

  localparam pie_row_type ROWS [11] = '{
    '{`PIE_OFF_IRQ_EN, 16'h007F, 4'h1, 16'h007F, `PIE_RESP_OKAY},
    '{`PIE_OFF_IRQ_EN, 16'hFFFF, 4'h3, 16'h007F, `PIE_RESP_OKAY},
    '{`PIE_OFF_IRQ_EN, 16'h0000, 4'h2, 16'h007F, `PIE_RESP_OKAY},
    '{`PIE_OFF_IRQ_EN, 16'h0000, 4'h1, 16'h0000, `PIE_RESP_OKAY},
    '{`PIE_OFF_FTX_CTL, 16'hFFFF, 4'h3, 16'h23B7, `PIE_RESP_OKAY},
    '{`PIE_OFF_FTX_CTL, 16'h0000, 4'h1, 16'h2314, `PIE_RESP_OKAY},
    '{`PIE_OFF_FTX_CTL, 16'h0000, 4'h2, 16'h0014, `PIE_RESP_OKAY},
    '{`PIE_OFF_FTX_CTL, 16'h0123, 4'h3, 16'h0137, `PIE_RESP_OKAY},
    '{`PIE_OFF_FTX_CTL, 16'h0180, 4'h3, 16'h0194, `PIE_RESP_OKAY},
    '{8'h00, 16'hFFFF, 4'h3, 16'h0000, `PIE_RESP_SLVERR},
    '{8'hE0, 16'hFFFF, 4'h3, 16'h0000, `PIE_RESP_SLVERR}
  };

  pie_regs i_pie_regs (
    .ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .evt, .negotiation_done, .operating_state,
    .mac_loop_mode, .ftx, .phy_irq
  );

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Reporting and compares
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic fail_msg(input string m);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail_msg

  task automatic check_data(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) fail_msg($sformatf("%s got %h exp %h", m, got, exp));
  endtask : check_data

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp, input string m);
    n_compared++;
    if (got !== exp) fail_msg($sformatf("%s resp %h exp %h", m, got, exp));
  endtask : check_resp

  task automatic check_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) fail_msg($sformatf("%s got %b exp %b", m, got, exp));
  endtask : check_bit

  task automatic check_ftx(input pie_ftx_type got, input pie_ftx_type exp, input string m);
    n_compared++;
    if (got !== exp) fail_msg($sformatf("%s got %h exp %h", m, got, exp));
  endtask : check_ftx

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic axi_wr(input logic [7:0] a, input logic [15:0] dv, input logic [3:0] s,
                        output logic [1:0] rs);
    logic aw_p;
    logic w_p;
    int n;
    aw_p = 1'b1;
    w_p = 1'b1;
    rs = 2'bxx;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, dv};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (aw_p && s_axi_awready) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n == 40) fail_msg("write hung");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    int n;
    dv = 32'hxxxxxxxx;
    rs = 2'bxx;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        dv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) fail_msg("read hung");
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [15:0] dv, input logic [3:0] s);
    logic [1:0] rs;
    axi_wr(a, dv, s, rs);
    check_resp(rs, `PIE_RESP_OKAY, "setup write");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [1:0] rs;
    logic [31:0] dv;
    axi_rd(a, dv, rs);
    check_data(dv, exp, "read");
    check_resp(rs, `PIE_RESP_OKAY, "read");
  endtask : rd

  task automatic pulse(input pie_evt_type v);
    @(posedge ref_clk);
    evt <= v;
    @(posedge ref_clk);
    evt <= '0;
  endtask : pulse

  task automatic chk_reset;
    check_ftx(ftx, 7'h18, "ftx reset");
    check_bit(phy_irq, 1'b0, "irq reset");
    rd(`PIE_OFF_IRQ_EN, 32'h0);
    rd(`PIE_OFF_FTX_CTL, 32'h0180 | (32'(operating_state) << 2));
    rd(`PIE_OFF_EVT_STATUS, 32'h0);
  endtask : chk_reset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    chk_reset;
    foreach (ROWS[i]) begin
      axi_wr(ROWS[i].a, ROWS[i].d, ROWS[i].s, r);
      check_resp(r, ROWS[i].r, "bresp");
      axi_rd(ROWS[i].a, d, r);
      check_data(d, {16'h0000, ROWS[i].e}, "readback");
      check_resp(r, ROWS[i].r, "rresp");
      if (ROWS[i].a == `PIE_OFF_FTX_CTL) check_ftx(ftx, {ROWS[i].e[13], ROWS[i].e[9],
        ROWS[i].e[8], ROWS[i].e[7], ROWS[i].e[5], ROWS[i].e[1], ROWS[i].e[0]}, "ftx");
    end
    for (int m = 0; m < 8; m++) begin
      operating_state <= 3'(m);
      cyc(2);
      rd(`PIE_OFF_FTX_CTL, 32'h0180 | (32'(m) << 2));
    end
    negotiation_done <= 1'b1;
    cyc(3);
    rd(`PIE_OFF_FTX_CTL, 32'h119C);
    rd(`PIE_OFF_EVT_STATUS, 32'h40);
    negotiation_done <= 1'b0;
    cyc(2);
    for (int i = 1; i < 7; i++) begin
      for (int en = 0; en < 2; en++) begin
        wr(`PIE_OFF_IRQ_EN, en ? 16'(1 << i) : 16'(~(1 << i) & 16'h007F), 4'h1);
        if (i == 6) negotiation_done <= 1'b1;
        else pulse(pie_evt_type'(6'(1 << i)));
        cyc(3);
        check_bit(phy_irq, 1'(en), "irq gate");
        rd(`PIE_OFF_EVT_STATUS, 32'h1 << i);
        rd(`PIE_OFF_EVT_STATUS, 32'h0);
        check_bit(phy_irq, 1'b0, "irq after clear");
        negotiation_done <= 1'b0;
      end
    end
    wr(`PIE_OFF_IRQ_EN, 16'h0001, 4'h1);
    repeat (63) pulse(6'h01);
    cyc(2);
    check_bit(phy_irq, 1'b0, "63 errors");
    pulse(6'h01);
    cyc(2);
    check_bit(phy_irq, 1'b1, "64 errors");
    rd(`PIE_OFF_EVT_STATUS, 32'h1);
    wr(`PIE_OFF_FTX_CTL, 16'h2180, 4'h3);
    repeat (70) pulse(6'h01);
    cyc(2);
    check_bit(phy_irq, 1'b0, "counter off");
    rd(`PIE_OFF_EVT_STATUS, 32'h0);
    wr(`PIE_OFF_FTX_CTL, 16'h0380, 4'h3);
    mac_loop_mode <= 2'h2;
    cyc(2);
    check_bit(ftx.far_loopback_en, 1'b0, "loop with mac loop");
    rd(`PIE_OFF_FTX_CTL, 32'h039C);
    mac_loop_mode <= 2'h0;
    cyc(2);
    check_bit(ftx.far_loopback_en, 1'b1, "loop allowed");
    pulse(6'h10);
    fork
      axi_rd(`PIE_OFF_EVT_STATUS, d, r);
      pulse(6'h10);
    join
    check_data(d, 32'h10, "read with event");
    check_resp(r, `PIE_RESP_OKAY, "read with event");
    rd(`PIE_OFF_EVT_STATUS, 32'h10);
    wr(`PIE_OFF_IRQ_EN, 16'h007F, 4'h1);
    pulse(6'h02);
    cyc(2);
    check_bit(phy_irq, 1'b1, "irq before reset");
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    chk_reset;
    finish_test;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_msg("timeout");
    finish_test;
  end
endmodule : phy_irq_enable_and_fast_tx_control_tb
